//--- shared/csc_pkg.sv
// Purpose: shared constants for the cpu system clock select block and its cpu-side end
// Assumes: one 100 MHz core clock; oscillators are modelled as tick dividers of it
// Notes: Behaviour list below uses the tags found in the design files
// Behaviour
// - processor clock ctrl: rate bits, mode bits
// - mode bits enter standby; release clears them
// - register write loads rate, zeroes mode
// - stop sets bit 3, halt bit 2
// - standby and clock ops ignore bank flag
// - on subsystem clock cpu runs sub/4
// - stop only honoured on main clock
// - reset clears processor clock ctrl
// - system clock ctrl: source bit, oscillator stop
// - software changes source/stop bits separately
// - oscillator stop acts only on subsystem clock
// - reset clears system clock ctrl
// - software waits switch latency before stop
// - stop bit grounds main oscillator input
// - no divide-by-16 code with subsystem clock
// - new selection applies after some cycles
// - latency per old rate; from sub one
// - reset starts slowest rate after stabilisation
// - low power: switch, wait 32, stop
// - full speed: restart, wait stable, switch
// - external main clock forbids stop mode
// - four main rates, fx/64 to fx/4
// - on subsystem clock halt ok, stop not
`default_nettype none
package csc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam longint STAB_TIME_NS = 21_800_000;
  localparam int STAB_CYC_DEF = int'((STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int MAIN_DIV_DEF = 17;
  localparam int SUB_DIV_DEF = 3052;
  localparam logic [3:0] PCC_RST = 4'h0;
  localparam logic [3:0] SCC_RST = 4'h0;
  localparam logic [3:0] PCC_DIV16_CODE = 4'h1;
  localparam logic [1:0] RATE_DIV16 = 2'h1;
  localparam int PCC_STOP_BIT = 3;
  localparam int PCC_HALT_BIT = 2;
  localparam int SCC_SRC_BIT = 0;
  localparam int SCC_MSTOP_BIT = 3;
  localparam int PHI_DIV [4] = '{64, 16, 8, 4};
  localparam int SW_LAT [4] = '{1, 4, 8, 16};
  localparam int SUB_PHI_DIV = 4;
  localparam int SUB_SW_WAIT = 32;
  localparam logic [1:0] REG_PCC = 2'h0;
  localparam logic [1:0] REG_CMD = 2'h1;
  localparam logic [1:0] REG_SCC = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  localparam int CMD_HALT = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_REL = 2;
  localparam int CMD_CLR_REF = 3;
  localparam int SCCW_VAL = 0;
  localparam int SCCW_SEL = 1;
endpackage : csc_pkg
`default_nettype wire

//--- shared/csc_if.sv
// Purpose: link between the cpu core end and the clock generator end
// Assumes: both ends on core_clk; every signal driven from a flip-flop
// Notes: strobes are one-cycle pulses
`default_nettype none
interface csc_if;
  logic pcc_wr;
  logic [1:0] pcc_wdata;
  logic halt_exec;
  logic stop_exec;
  logic standby_release;
  logic scc_bit_wr;
  logic scc_bit_sel;
  logic scc_bit_val;
  logic [3:0] pcc_q;
  logic [3:0] scc_q;
  logic phi_tick;
  logic cpu_run;
  logic on_sub;
  logic main_stable;
  logic sw_busy;
  modport dev (input pcc_wr, pcc_wdata, halt_exec, stop_exec, standby_release, scc_bit_wr,
    scc_bit_sel, scc_bit_val, output pcc_q, scc_q, phi_tick, cpu_run, on_sub, main_stable,
    sw_busy);
  modport cpu (output pcc_wr, pcc_wdata, halt_exec, stop_exec, standby_release, scc_bit_wr,
    scc_bit_sel, scc_bit_val, input pcc_q, scc_q, phi_tick, cpu_run, on_sub, main_stable,
    sw_busy);
endinterface : csc_if
`default_nettype wire

//--- rtl/csc_clkgen.sv
// Purpose: clock generator end: control registers, oscillator gating, cpu clock select
// Assumes: oscillators modelled as ticks every MAIN_DIV / SUB_DIV core cycles
// Notes: cpu clock is delivered as the one-cycle phi_tick, one per machine cycle
`default_nettype none
module csc_clkgen
  import csc_pkg::*;
#(
  parameter int STAB_CYC = STAB_CYC_DEF,
  parameter int MAIN_DIV = MAIN_DIV_DEF,
  parameter int SUB_DIV = SUB_DIV_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  csc_if.dev link,
  output logic main_osc_gnd,
  output logic main_osc_on
);
  localparam int SW = $clog2(STAB_CYC + 1);
  localparam int MW = $clog2(MAIN_DIV + 1);
  localparam int XW = $clog2(SUB_DIV + 1);

  logic [3:0] pcc_ff;
  logic [3:0] scc_ff;
  logic sel_sub_ff;
  logic [1:0] sel_rate_ff;
  logic pend_ff;
  logic [4:0] lat_ff;
  logic sub_seen_ff;
  logic [MW-1:0] mdiv_ff;
  logic [XW-1:0] xdiv_ff;
  logic [5:0] phi_cnt_ff;
  logic [SW-1:0] stab_ff;
  logic stab_done_ff;

  logic main_run;
  logic main_tick;
  logic sub_tick;
  logic src_tick;
  logic [5:0] div_m1;
  logic phi_edge;
  logic mismatch;
  logic to_sub;
  logic apply_sw;

  // main oscillator stops in stop mode, or by the stop bit only while on the subsystem clock
  assign main_run = !pcc_ff[PCC_STOP_BIT]
                    && !(scc_ff[SCC_MSTOP_BIT] && sel_sub_ff);
  assign main_tick = main_run && (mdiv_ff == '0);
  assign sub_tick = (xdiv_ff == '0);
  // no cpu edges from the main source until it has settled
  assign src_tick = sel_sub_ff ? sub_tick : (main_tick && stab_done_ff);
  assign div_m1 = sel_sub_ff ? 6'(SUB_PHI_DIV - 1)
                             : 6'(PHI_DIV[sel_rate_ff] - 1);
  assign phi_edge = src_tick && (phi_cnt_ff == div_m1);
  // rate bits only matter while the main clock is wanted
  assign mismatch = (scc_ff[SCC_SRC_BIT] != sel_sub_ff)
                    || (!scc_ff[SCC_SRC_BIT] && (pcc_ff[1:0] != sel_rate_ff));
  assign to_sub = scc_ff[SCC_SRC_BIT] && !sel_sub_ff;
  // the switch lands on a phi boundary so no short cpu cycle is produced
  assign apply_sw = pend_ff && phi_edge
                    && (to_sub ? sub_seen_ff : (lat_ff <= 5'h01));

  // processor clock control
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pcc_ff <= PCC_RST;
    end else begin
      if (link.standby_release) begin
        pcc_ff[PCC_STOP_BIT] <= 1'b0;
        pcc_ff[PCC_HALT_BIT] <= 1'b0;
      end
      if (link.pcc_wr) begin
        pcc_ff <= {2'b00, link.pcc_wdata};
      end
      // no bank qualifier on these strobes; halt always reaches the register, stop only while the main clock is in force and wanted
      if (link.halt_exec) begin
        pcc_ff[PCC_HALT_BIT] <= 1'b1;
      end
      if (link.stop_exec && !sel_sub_ff && !scc_ff[SCC_SRC_BIT]) begin
        pcc_ff[PCC_STOP_BIT] <= 1'b1;
      end
    end
  end

  // system clock control, written a bit at a time
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scc_ff <= SCC_RST;
    end else if (link.scc_bit_wr) begin
      if (link.scc_bit_sel) begin
        scc_ff[SCC_MSTOP_BIT] <= link.scc_bit_val;
      end else begin
        scc_ff[SCC_SRC_BIT] <= link.scc_bit_val;
      end
    end
  end

  // oscillator models
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mdiv_ff <= '0;
    end else if (!main_run) begin
      mdiv_ff <= '0;
    end else if (mdiv_ff == MW'(MAIN_DIV - 1)) begin
      mdiv_ff <= '0;
    end else begin
      mdiv_ff <= mdiv_ff + MW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xdiv_ff <= '0;
    end else if (xdiv_ff == XW'(SUB_DIV - 1)) begin
      xdiv_ff <= '0;
    end else begin
      xdiv_ff <= xdiv_ff + XW'(1);
    end
  end

  // stabilisation wait restarts whenever the main oscillator is restarted
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stab_ff <= '0;
      stab_done_ff <= 1'b0;
    end else if (!main_run) begin
      stab_ff <= '0;
      stab_done_ff <= 1'b0;
    end else if (!stab_done_ff) begin
      stab_ff <= stab_ff + SW'(1);
      stab_done_ff <= (stab_ff == SW'(STAB_CYC - 1));
    end
  end

  // machine cycle divider
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phi_cnt_ff <= 6'h00;
    end else if (phi_edge) begin
      phi_cnt_ff <= 6'h00;
    end else if (src_tick) begin
      phi_cnt_ff <= phi_cnt_ff + 6'h01;
    end
  end

  // selection in force; reset gives main clock at the slowest rate
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_sub_ff <= 1'b0;
      sel_rate_ff <= 2'h0;
    end else if (apply_sw) begin
      sel_sub_ff <= scc_ff[SCC_SRC_BIT];
      sel_rate_ff <= pcc_ff[1:0];
    end
  end

  // switch latency: counted in machine cycles of the clock in force
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_ff <= 1'b0;
      lat_ff <= 5'h00;
      sub_seen_ff <= 1'b0;
    end else begin
      pend_ff <= mismatch && !apply_sw;
      if (!pend_ff && mismatch) begin
        lat_ff <= sel_sub_ff ? 5'h01 : 5'(SW_LAT[sel_rate_ff]);
        sub_seen_ff <= 1'b0;
      end else begin
        if (pend_ff && phi_edge && lat_ff > 5'h01) begin
          lat_ff <= lat_ff - 5'h01;
        end
        // moving onto the subsystem clock waits for its next edge, up to one sub period
        if (sub_tick) begin
          sub_seen_ff <= 1'b1;
        end
      end
    end
  end

  // outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      link.pcc_q <= PCC_RST;
      link.scc_q <= SCC_RST;
      link.phi_tick <= 1'b0;
      link.cpu_run <= 1'b0;
      link.on_sub <= 1'b0;
      link.main_stable <= 1'b0;
      link.sw_busy <= 1'b0;
      main_osc_gnd <= 1'b0;
      main_osc_on <= 1'b1;
    end else begin
      link.pcc_q <= pcc_ff;
      link.scc_q <= scc_ff;
      link.phi_tick <= phi_edge && !pcc_ff[PCC_STOP_BIT] && !pcc_ff[PCC_HALT_BIT];
      link.cpu_run <= !pcc_ff[PCC_STOP_BIT] && !pcc_ff[PCC_HALT_BIT]
                      && (sel_sub_ff || stab_done_ff);
      link.on_sub <= sel_sub_ff;
      link.main_stable <= stab_done_ff;
      link.sw_busy <= pend_ff;
      // grounding the crystal input avoids leakage while it is idle
      main_osc_gnd <= scc_ff[SCC_MSTOP_BIT] || pcc_ff[PCC_STOP_BIT];
      main_osc_on <= main_run;
    end
  end
endmodule : csc_clkgen
`default_nettype wire

//--- rtl/csc_cpu_end.sv
// Purpose: cpu-side end: turns software register accesses into standby and clock strobes
// Assumes: software port with one-cycle strobes, read data the cycle after
// Notes: unsafe requests are dropped and latched in a sticky refused flag
`default_nettype none
module csc_cpu_end
  import csc_pkg::*;
#(
  parameter bit EXT_MAIN = 1'b0
) (
  input wire logic core_clk,
  input wire logic rstn,
  csc_if.cpu link,
  input wire logic [1:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata
);
  logic refused_ff;
  logic [5:0] sub_wait_ff;
  logic wait_done;
  logic ref_pcc;
  logic ref_stop;
  logic ref_scc;
  logic wr_pcc;
  logic wr_cmd;
  logic wr_scc;
  logic scc_sel;
  logic scc_val;

  assign wr_pcc = sw_wr && (sw_addr == REG_PCC);
  assign wr_cmd = sw_wr && (sw_addr == REG_CMD);
  assign wr_scc = sw_wr && (sw_addr == REG_SCC);
  assign scc_sel = sw_wdata[SCCW_SEL];
  assign scc_val = sw_wdata[SCCW_VAL];
  assign wait_done = (sub_wait_ff == 6'(SUB_SW_WAIT));
  assign ref_pcc = link.on_sub && (sw_wdata[1:0] == RATE_DIV16);
  assign ref_stop = EXT_MAIN;
  // one bit per access, so source and stop bit never change together
  assign ref_scc = scc_sel
    ? (scc_val && (EXT_MAIN || !link.on_sub || !wait_done))
    : (scc_val ? (link.pcc_q == PCC_DIV16_CODE)
               : (!link.main_stable || link.scc_q[SCC_MSTOP_BIT]));

  // machine cycles spent on the subsystem clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sub_wait_ff <= 6'h00;
    end else if (!link.on_sub) begin
      sub_wait_ff <= 6'h00;
    end else if (link.phi_tick && !wait_done) begin
      sub_wait_ff <= sub_wait_ff + 6'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      link.pcc_wr <= 1'b0;
      link.pcc_wdata <= 2'h0;
      link.halt_exec <= 1'b0;
      link.stop_exec <= 1'b0;
      link.standby_release <= 1'b0;
      link.scc_bit_wr <= 1'b0;
      link.scc_bit_sel <= 1'b0;
      link.scc_bit_val <= 1'b0;
    end else begin
      link.pcc_wr <= wr_pcc && !ref_pcc;
      link.pcc_wdata <= sw_wdata[1:0];
      link.halt_exec <= wr_cmd && sw_wdata[CMD_HALT];
      link.stop_exec <= wr_cmd && sw_wdata[CMD_STOP] && !ref_stop;
      link.standby_release <= wr_cmd && sw_wdata[CMD_REL];
      link.scc_bit_wr <= wr_scc && !ref_scc;
      link.scc_bit_sel <= scc_sel;
      link.scc_bit_val <= scc_val;
    end
  end

  // sticky refusal; a new refusal beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      refused_ff <= 1'b0;
    end else if ((wr_pcc && ref_pcc) || (wr_scc && ref_scc)
                 || (wr_cmd && sw_wdata[CMD_STOP] && ref_stop)) begin
      refused_ff <= 1'b1;
    end else if (wr_cmd && sw_wdata[CMD_CLR_REF]) begin
      refused_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sw_rdata <= 8'h00;
    end else if (!sw_rd) begin
      sw_rdata <= 8'h00;
    end else if (sw_addr == REG_PCC) begin
      sw_rdata <= {4'h0, link.pcc_q};
    end else if (sw_addr == REG_SCC) begin
      sw_rdata <= {4'h0, link.scc_q};
    end else if (sw_addr == REG_STAT) begin
      sw_rdata <= {link.sw_busy, link.on_sub, link.main_stable, link.cpu_run,
                   wait_done, refused_ff, 2'h0};
    end else begin
      sw_rdata <= 8'h00;
    end
  end
endmodule : csc_cpu_end
`default_nettype wire

//--- bench/csc_checker_sva.sv
// Purpose: temporal checks on the link between the cpu end and the clock generator
// Assumes: one clock domain; watches link signals only
// Notes: gap_ff counts core cycles since the last cpu clock tick
`default_nettype none
module csc_checker
  import csc_pkg::*;
#(
  parameter int SUB_DIV = SUB_DIV_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pcc_wr,
  input wire logic [1:0] pcc_wdata,
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic standby_release,
  input wire logic scc_bit_wr,
  input wire logic scc_bit_sel,
  input wire logic scc_bit_val,
  input wire logic [3:0] pcc_q,
  input wire logic [3:0] scc_q,
  input wire logic phi_tick,
  input wire logic on_sub
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] gap_ff;
  logic sub_tick_ff;
  logic sub_old_ff;
  // the first cycle after a switch is not aligned to the sub oscillator, so only
  // cycles that start and end on the subsystem clock are timed
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gap_ff <= 16'h0;
      sub_tick_ff <= 1'b0;
      sub_old_ff <= 1'b0;
    end else begin
      gap_ff <= phi_tick ? 16'h0 : gap_ff + 16'h1;
      sub_old_ff <= phi_tick ? on_sub : sub_old_ff;
      sub_tick_ff <= phi_tick ? (on_sub && sub_old_ff) : sub_tick_ff;
    end
  end
  // standby set in the same cycle beats the rate load
  property p_wr_rate;
    pcc_wr && !halt_exec && !stop_exec |-> ##2 pcc_q == {2'h0, $past(pcc_wdata, 2)};
  endproperty
  a_wr_rate: assert property (p_wr_rate) else $error("rate write not loaded");
  property p_halt_set;
    halt_exec |-> ##2 pcc_q[PCC_HALT_BIT];
  endproperty
  a_halt_set: assert property (p_halt_set) else $error("halt bit not set");
  property p_sub_nostop;
    stop_exec && on_sub |-> ##2 !pcc_q[PCC_STOP_BIT];
  endproperty
  a_sub_nostop: assert property (p_sub_nostop) else $error("stop taken on sub");
  property p_release;
    standby_release && !halt_exec && !stop_exec |-> ##2 pcc_q[3:2] == 2'h0;
  endproperty
  a_release: assert property (p_release) else $error("release left mode bits");
  property p_scc_src;
    scc_bit_wr && !scc_bit_sel |-> ##2 scc_q[SCC_SRC_BIT] == $past(scc_bit_val, 2);
  endproperty
  a_scc_src: assert property (p_scc_src) else $error("source bit wrong");
  property p_scc_stop;
    scc_bit_wr && scc_bit_sel |-> ##2 scc_q[SCC_MSTOP_BIT] == $past(scc_bit_val, 2);
  endproperty
  a_scc_stop: assert property (p_scc_stop) else $error("main stop bit wrong");
  property p_mstop_sub;
    scc_q[SCC_MSTOP_BIT] |-> on_sub;
  endproperty
  a_mstop_sub: assert property (p_mstop_sub) else $error("main stop off sub");
  property p_sub_code;
    on_sub |-> pcc_q != PCC_DIV16_CODE;
  endproperty
  a_sub_code: assert property (p_sub_code) else $error("div16 code on sub");
  property p_sub_rate;
    phi_tick && on_sub && sub_tick_ff |-> gap_ff >= 16'(SUB_PHI_DIV * SUB_DIV - 1);
  endproperty
  a_sub_rate: assert property (p_sub_rate) else $error("sub cpu clock too fast");
endmodule : csc_checker
`default_nettype wire

//--- bench/csc_bench.sv
// Purpose: drives both ends through the software port and checks results
// Assumes: shortened stabilisation and subsystem divider
// Notes: reads queue their expectation; a watcher compares the data
`default_nettype none
module csc_bench
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SDIV = 40;
  localparam int LIM = 20000;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] sw_addr = 2'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic pend = 1'b0;
  logic [7:0] sw_rdata;
  logic gnd;
  logic osc_on;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h27EE;
  logic [31:0] n;
  csc_if link();
  csc_clkgen #(.STAB_CYC(50), .SUB_DIV(SDIV)) csc_clkgen_inst (.core_clk(core_clk),
    .rstn(rstn), .link(link), .main_osc_gnd(gnd), .main_osc_on(osc_on));
  csc_cpu_end csc_cpu_end_inst (.core_clk(core_clk), .rstn(rstn), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  csc_checker #(.SUB_DIV(SDIV)) csc_checker_inst (.core_clk(core_clk), .rstn(rstn),
    .pcc_wr(link.pcc_wr), .pcc_wdata(link.pcc_wdata), .halt_exec(link.halt_exec),
    .stop_exec(link.stop_exec), .standby_release(link.standby_release),
    .scc_bit_wr(link.scc_bit_wr), .scc_bit_sel(link.scc_bit_sel),
    .scc_bit_val(link.scc_bit_val), .pcc_q(link.pcc_q), .scc_q(link.scc_q),
    .phi_tick(link.phi_tick), .on_sub(link.on_sub));
  always #5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
    // the register copy on the link lags the strobe by two more cycles
    repeat (2) @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : rd
  // read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (pend) begin
      check({24'h0, sw_rdata & msk_q.pop_front()}, {24'h0, exp_q.pop_front()});
    end
    pend <= sw_rd;
  end
  function automatic logic sig(input int k);
    case (k)
      0: return link.sw_busy;
      1: return link.on_sub;
      2: return link.main_stable;
      default: return link.phi_tick;
    endcase
  endfunction : sig
  task automatic waitv(input int k, input logic v);
    for (int i = 0; i < LIM; i++) begin
      @(posedge core_clk);
      if (sig(k) === v) return;
    end
    num_errors++;
    $display("wrong value at %0t: wait %0d timed out", $time, k);
    conclude();
  endtask : waitv
  task automatic gap(input logic [31:0] e);
    time t0;
    waitv(3, 1'b1);
    t0 = $time;
    waitv(3, 1'b1);
    check(32'(($time - t0) / 10), e);
  endtask : gap
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    rd(REG_PCC, PCC_RST, 8'h0F);
    rd(REG_SCC, SCC_RST, 8'h0F);
    check({gnd, osc_on}, 2'b01);
    waitv(2, 1'b1);
    gap(32'(PHI_DIV[0] * MAIN_DIV_DEF));
    $display("test reset done");
    for (int k = 3; k >= 0; k--) begin
      n = rnd();
      wr(REG_PCC, {n[7:2], k[1:0]});
      rd(REG_PCC, 8'(k), 8'h0F);
      waitv(0, 1'b0);
      gap(32'(PHI_DIV[k] * MAIN_DIV_DEF));
    end
    $display("test rates done");
    wr(REG_PCC, 8'h03);
    waitv(0, 1'b0);
    wr(REG_CMD, 8'h01);
    rd(REG_PCC, 8'h07, 8'h0F);
    rd(REG_STAT, 8'h00, 8'h10);
    wr(REG_CMD, 8'h04);
    rd(REG_PCC, 8'h03, 8'h0F);
    wr(REG_CMD, 8'h02);
    rd(REG_PCC, 8'h0B, 8'h0F);
    check(gnd, 1'b1);
    wr(REG_CMD, 8'h04);
    rd(REG_PCC, 8'h03, 8'h0F);
    waitv(2, 1'b1);
    $display("test standby done");
    wr(REG_PCC, 8'h01);
    waitv(0, 1'b0);
    wr(REG_SCC, 8'h01);
    rd(REG_SCC, 8'h00, 8'h0F);
    rd(REG_STAT, 8'h04, 8'h04);
    wr(REG_CMD, 8'h08);
    wr(REG_PCC, 8'h03);
    waitv(0, 1'b0);
    n = rnd();
    wr(REG_SCC, {n[7:2], 2'b01});
    waitv(1, 1'b1);
    // main stop asked before the switch wait has run out
    wr(REG_SCC, 8'h03);
    rd(REG_SCC, 8'h01, 8'h0F);
    rd(REG_STAT, 8'h44, 8'h44);
    wr(REG_CMD, 8'h08);
    wr(REG_CMD, 8'h02);
    rd(REG_PCC, 8'h03, 8'h0F);
    wr(REG_CMD, 8'h01);
    rd(REG_PCC, 8'h07, 8'h0F);
    wr(REG_CMD, 8'h04);
    gap(32'(SUB_PHI_DIV * SDIV));
    repeat (SUB_SW_WAIT) waitv(3, 1'b1);
    wr(REG_SCC, 8'h03);
    rd(REG_SCC, 8'h09, 8'h0F);
    check({gnd, osc_on}, 2'b10);
    wr(REG_SCC, 8'h00);
    rd(REG_STAT, 8'h44, 8'h44);
    wr(REG_CMD, 8'h08);
    wr(REG_SCC, 8'h02);
    waitv(2, 1'b1);
    wr(REG_SCC, 8'h00);
    waitv(1, 1'b0);
    rd(REG_SCC, 8'h00, 8'h0F);
    gap(32'(PHI_DIV[3] * MAIN_DIV_DEF));
    $display("test low power done");
    conclude();
  end
endmodule : csc_bench
`default_nettype wire
